// file: core/nscr_regs.v
// Node configuration register bank of the system switch, with PLL update sequencer
// Contract
// - Registers reached by config read/write, selected by register number
// - Identification: boot pins at reset 23:16, revision 15:8, version 7:0
// - Description: switch links 23:16, switch processors 15:8, device processors 7:0
// - Config bit 31 set blocks writes to switch control registers
// - Config bit 8 set refuses writes to the PLL control register
// - Config bit 0 selects header size: 0 two-byte, 1 one-byte; resets 0
// - All defined config bits reset to zero
// - Node identifier 15:0 writable, resets zero; upper bits read-only
// - PLL output clocks I/O logic, processors and switch
// - Any accepted PLL settings write resets the tile after applying settings
// - PLL write with bit 31 set applies settings without chip reset
// - PLL write with bit 30 set does not wait for PLL lock
// - Writing 1 to PLL bit 29 bypasses the PLL; write-only bit
// - Writing 1 to PLL bit 28 forces boot from JTAG; write-only bit
// - Output divider 25:23 holds divide value minus one
// - Feedback multiplier 20:8 holds ratio minus one
// - Input divider 6:0 holds divide value minus one
`timescale 1ns/1ps
`default_nettype none
`include "nscr_map.vh"

module nscr_regs #(
    parameter [7:0]  SW_REVISION  = 8'h01,
    parameter [7:0]  SW_VERSION   = 8'h01,
    parameter [7:0]  NUM_LINKS    = 8'h08,
    parameter [7:0]  NUM_SW_PROCS = 8'h02,
    parameter [7:0]  NUM_DEV_PROCS = 8'h02,
    // Identification values below are arbitrary
    parameter [31:0] JTAG_ID      = 32'h0000_0001,
    parameter [31:0] USER_CODE    = 32'h0000_0000
) (
    input  wire        mclk,
    input  wire        nrst,
    input  wire        cfg_req,
    input  wire        cfg_write,
    input  wire [7:0]  cfg_regnum,
    input  wire [31:0] cfg_wdata,
    output reg         cfg_ack,
    output reg         cfg_err,
    output reg  [31:0] cfg_rdata,
    input  wire [7:0]  boot_control_pins,
    input  wire [4:0]  debug_source,
    input  wire        pll_locked,
    output wire        hdr_one_byte,
    output wire [15:0] node_id,
    output reg         pll_load,
    output wire [2:0]  pll_out_div,
    output wire [12:0] pll_fb_mult,
    output wire [6:0]  pll_in_div,
    output reg         pll_bypass,
    output reg         boot_from_jtag,
    output reg         tile_reset,
    output reg         chip_reset,
    output wire [15:0] switch_clk_div,
    output wire [15:0] ref_clk_div,
    output wire [31:0] route_dir_low,
    output wire [31:0] route_dir_high,
    output wire [1:0]  debug_cfg_tile0,
    output wire [1:0]  debug_cfg_tile1
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_APPLY = 2'h1;
    localparam [1:0] ST_LOCK  = 2'h2;
    localparam [1:0] ST_RST   = 2'h3;

    reg [31:0] swcfg;
    reg [31:0] nodeid;
    reg [31:0] pll;
    reg [31:0] swdiv;
    reg [31:0] refdiv;
    reg [31:0] dirlo;
    reg [31:0] dirhi;
    reg [31:0] dbg0;
    reg [31:0] dbg1;
    reg [7:0]  boot_cap;
    reg        boot_done;
    reg [1:0]  state;
    reg [1:0]  next_state;
    reg        pend_chip;
    reg [31:0] next_rdata;
    reg        next_err;

    function in_range;
        input [7:0] rn;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (rn >= lo) && (rn <= hi);
        end
    endfunction

    wire wr       = cfg_req & cfg_write;
    wire sw_lock  = swcfg[`NSCR_SWCFG_LOCK];
    wire pll_lock = swcfg[`NSCR_SWCFG_PLLLOCK];
    wire wr_ok    = wr & ~sw_lock;
    wire pll_wr   = wr_ok & ~pll_lock & (cfg_regnum == `NSCR_RN_PLL);
    wire reg_wr_ok = wr_ok & (state == ST_IDLE);

    // Header mode, node identity and clocking fields straight from storage
    assign hdr_one_byte    = swcfg[`NSCR_SWCFG_HDR];
    assign node_id         = nodeid[15:0];
    assign pll_out_div     = pll[`NSCR_PLL_OD_HI:`NSCR_PLL_OD_LO];
    assign pll_fb_mult     = pll[`NSCR_PLL_FB_HI:`NSCR_PLL_FB_LO];
    assign pll_in_div      = pll[`NSCR_PLL_IN_HI:`NSCR_PLL_IN_LO];
    assign switch_clk_div  = swdiv[15:0];
    assign ref_clk_div     = refdiv[15:0];
    assign route_dir_low   = dirlo;
    assign route_dir_high  = dirhi;
    assign debug_cfg_tile0 = dbg0[1:0];
    assign debug_cfg_tile1 = dbg1[1:0];

    // Boot pins caught on the first edge after reset release
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_cap  <= 8'h00;
            boot_done <= 1'b0;
        end else if (!boot_done) begin
            boot_cap  <= boot_control_pins;
            boot_done <= 1'b1;
        end
    end

    // Writable storage; reserved bits masked off on write
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            swcfg  <= `NSCR_SWCFG_RST;
            nodeid <= `NSCR_NODEID_RST;
            swdiv  <= `NSCR_SWDIV_RST;
            refdiv <= `NSCR_REFDIV_RST;
            dirlo  <= `NSCR_DIR_RST;
            dirhi  <= `NSCR_DIR_RST;
            dbg0   <= `NSCR_DBG_RST;
            dbg1   <= `NSCR_DBG_RST;
        end else if (reg_wr_ok) begin
            case (cfg_regnum)
                `NSCR_RN_SWCFG: begin
                    swcfg <= cfg_wdata & `NSCR_SWCFG_MASK;
                end
                `NSCR_RN_NODEID: begin
                    nodeid <= cfg_wdata & `NSCR_NODEID_MASK;
                end
                `NSCR_RN_SWDIV: begin
                    swdiv <= cfg_wdata & `NSCR_DIV_MASK;
                end
                `NSCR_RN_REFDIV: begin
                    refdiv <= cfg_wdata & `NSCR_DIV_MASK;
                end
                `NSCR_RN_DIRLO: begin
                    dirlo <= cfg_wdata;
                end
                `NSCR_RN_DIRHI: begin
                    dirhi <= cfg_wdata;
                end
                `NSCR_RN_DBG0: begin
                    dbg0 <= cfg_wdata & `NSCR_DBG_MASK;
                end
                `NSCR_RN_DBG1: begin
                    dbg1 <= cfg_wdata & `NSCR_DBG_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // PLL settings and write-only command bits
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pll            <= `NSCR_PLL_RST;
            pll_bypass     <= 1'b0;
            boot_from_jtag <= 1'b0;
            pend_chip      <= 1'b0;
        end else if (pll_wr && state == ST_IDLE) begin
            pll            <= cfg_wdata & `NSCR_PLL_MASK;
            pll_bypass     <= cfg_wdata[`NSCR_PLL_BYPASS];
            boot_from_jtag <= boot_from_jtag | cfg_wdata[`NSCR_PLL_JTAGBOOT];
            pend_chip      <= ~cfg_wdata[`NSCR_PLL_NORST];
        end
    end

    // Update sequence: apply, optional wait for lock, then reset pulse
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (pll_wr) begin
                    next_state = ST_APPLY;
                end
            end
            ST_APPLY: begin
                if (pll[`NSCR_PLL_NOWAIT]) begin
                    next_state = ST_RST;
                end else begin
                    next_state = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (pll_locked) begin
                    next_state = ST_RST;
                end
            end
            ST_RST: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state      <= ST_IDLE;
            pll_load   <= 1'b0;
            tile_reset <= 1'b0;
            chip_reset <= 1'b0;
        end else begin
            state      <= next_state;
            pll_load   <= (state == ST_IDLE) & pll_wr;
            tile_reset <= (state != ST_RST) & (next_state == ST_RST);
            chip_reset <= (state != ST_RST) & (next_state == ST_RST) & pend_chip;
        end
    end

    // Read decode and refusal report
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (cfg_regnum)
            `NSCR_RN_IDENT: begin
                next_rdata = {8'h00, boot_cap, SW_REVISION, SW_VERSION};
            end
            `NSCR_RN_DESC: begin
                next_rdata = {8'h00, NUM_LINKS, NUM_SW_PROCS, NUM_DEV_PROCS};
            end
            `NSCR_RN_SWCFG: begin
                next_rdata = swcfg;
            end
            `NSCR_RN_NODEID: begin
                next_rdata = nodeid;
            end
            `NSCR_RN_PLL: begin
                next_rdata = pll;
            end
            `NSCR_RN_SWDIV: begin
                next_rdata = swdiv;
            end
            `NSCR_RN_REFDIV: begin
                next_rdata = refdiv;
            end
            `NSCR_RN_JTAGID: begin
                next_rdata = JTAG_ID;
            end
            `NSCR_RN_USERCODE: begin
                next_rdata = USER_CODE;
            end
            `NSCR_RN_DIRLO: begin
                next_rdata = dirlo;
            end
            `NSCR_RN_DIRHI: begin
                next_rdata = dirhi;
            end
            `NSCR_RN_DBG0: begin
                next_rdata = dbg0;
            end
            `NSCR_RN_DBG1: begin
                next_rdata = dbg1;
            end
            `NSCR_RN_DBGSRC: begin
                next_rdata = {27'h0, debug_source} & `NSCR_DBGSRC_MASK;
            end
            default: begin
                next_err = ~(in_range(cfg_regnum, `NSCR_RN_LINK_LO, `NSCR_RN_LINK_HI) |
                             in_range(cfg_regnum, `NSCR_RN_PROCESSOR_LINK_LO, `NSCR_RN_PROCESSOR_LINK_HI) |
                             in_range(cfg_regnum, `NSCR_RN_LCFG_LO, `NSCR_RN_LCFG_HI) |
                             in_range(cfg_regnum, `NSCR_RN_SLCFG_LO, `NSCR_RN_SLCFG_HI));
            end
        endcase
        if (cfg_write) begin
            next_rdata = 32'h0000_0000;
            if (sw_lock || state != ST_IDLE) begin
                next_err = 1'b1;
            end
            if (pll_lock && cfg_regnum == `NSCR_RN_PLL) begin
                next_err = 1'b1;
            end
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_ack   <= 1'b0;
            cfg_err   <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack   <= cfg_req;
            cfg_err   <= cfg_req & next_err;
            cfg_rdata <= cfg_req ? next_rdata : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// file: include/nscr_map.vh
// Register numbers, field positions, masks and reset values of the node config bank
`ifndef NSCR_MAP_VH
`define NSCR_MAP_VH

`define NSCR_RN_W          8
`define NSCR_DW            32

`define NSCR_RN_IDENT      8'h00
`define NSCR_RN_DESC       8'h01
`define NSCR_RN_SWCFG      8'h04
`define NSCR_RN_NODEID     8'h05
`define NSCR_RN_PLL        8'h06
`define NSCR_RN_SWDIV      8'h07
`define NSCR_RN_REFDIV     8'h08
`define NSCR_RN_JTAGID     8'h09
`define NSCR_RN_USERCODE   8'h0a
`define NSCR_RN_DIRLO      8'h0c
`define NSCR_RN_DIRHI      8'h0d
`define NSCR_RN_DBG0       8'h10
`define NSCR_RN_DBG1       8'h11
`define NSCR_RN_DBGSRC     8'h1f
`define NSCR_RN_LINK_LO    8'h20
`define NSCR_RN_LINK_HI    8'h28
`define NSCR_RN_PROCESSOR_LINK_LO   8'h40
`define NSCR_RN_PROCESSOR_LINK_HI   8'h47
`define NSCR_RN_LCFG_LO    8'h80
`define NSCR_RN_LCFG_HI    8'h88
`define NSCR_RN_SLCFG_LO   8'ha0
`define NSCR_RN_SLCFG_HI   8'ha7

`define NSCR_SWCFG_LOCK    31
`define NSCR_SWCFG_PLLLOCK 8
`define NSCR_SWCFG_HDR     0
`define NSCR_SWCFG_MASK    32'h8000_0101
`define NSCR_SWCFG_RST     32'h0000_0000

`define NSCR_NODEID_MASK   32'h0000_ffff
`define NSCR_NODEID_RST    32'h0000_0000

`define NSCR_PLL_NORST     31
`define NSCR_PLL_NOWAIT    30
`define NSCR_PLL_BYPASS    29
`define NSCR_PLL_JTAGBOOT  28
`define NSCR_PLL_OD_HI     25
`define NSCR_PLL_OD_LO     23
`define NSCR_PLL_FB_HI     20
`define NSCR_PLL_FB_LO     8
`define NSCR_PLL_IN_HI     6
`define NSCR_PLL_IN_LO     0
`define NSCR_PLL_MASK      32'hc39f_ff7f
`define NSCR_PLL_RST       32'h0000_0000

`define NSCR_DIV_MASK      32'h0000_ffff
`define NSCR_SWDIV_RST     32'h0000_0000
`define NSCR_REFDIV_RST    32'h0000_0003
`define NSCR_DIR_RST       32'h0000_0000
`define NSCR_DBG_MASK      32'h0000_0003
`define NSCR_DBG_RST       32'h0000_0000
`define NSCR_DBGSRC_MASK   32'h0000_0013

`define NSCR_ID_BOOT_LO    16
`define NSCR_ID_REV_LO     8
`define NSCR_ID_VER_LO     0

`endif

// file: tb/nscr_regs_sva.sv
// Assertion checker for the node configuration register bank
`timescale 1ns/1ps
`default_nettype none
module nscr_regs_sva (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        cfg_req,
    input wire logic        cfg_write,
    input wire logic [7:0]  cfg_regnum,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cfg_ack,
    input wire logic        cfg_err,
    input wire logic [31:0] cfg_rdata,
    input wire logic        pll_locked,
    input wire logic        hdr_one_byte,
    input wire logic [15:0] node_id,
    input wire logic        pll_load,
    input wire logic        tile_reset,
    input wire logic        chip_reset
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_ack_follows_req: assert property (cfg_req |=> cfg_ack) else $error("ack missing");
    a_ack_needs_req: assert property (!cfg_req |=> !cfg_ack) else $error("stray ack");
    a_rdata_idle_zero: assert property (!cfg_ack |-> cfg_rdata == 32'h0)
        else $error("rdata not zero when idle");
    a_write_rdata_zero: assert property (cfg_req && cfg_write |=> cfg_rdata == 32'h0)
        else $error("rdata not zero on write");
    a_hdr_by_write: assert property ($changed(hdr_one_byte)
        |-> $past(cfg_req && cfg_write && cfg_regnum == 8'h04)) else $error("header mode changed");
    a_node_by_write: assert property ($changed(node_id)
        |-> $past(cfg_req && cfg_write && cfg_regnum == 8'h05)) else $error("node id changed");
    a_load_on_pll_wr: assert property (pll_load
        |-> cfg_ack && !cfg_err && $past(cfg_write && cfg_regnum == 8'h06))
        else $error("pll load without accepted write");
    a_nowait_reset: assert property (pll_load && $past(cfg_wdata[30]) |=> tile_reset)
        else $error("no prompt tile reset");
    a_wait_for_lock: assert property (pll_load && !$past(cfg_wdata[30]) |=> !tile_reset)
        else $error("tile reset before lock");
    a_reset_cause: assert property (tile_reset |-> $past(pll_locked) || $past(pll_load))
        else $error("tile reset without cause");
    a_chip_with_tile: assert property (chip_reset |-> tile_reset)
        else $error("chip reset alone");
    a_no_chip_reset: assert property (pll_load && $past(cfg_wdata[31]) |=> !chip_reset [*4])
        else $error("chip reset when suppressed");

    c_pll_load: cover property (pll_load);
    c_tile_only: cover property (tile_reset && !chip_reset);
    c_refused: cover property (cfg_ack && cfg_err);
endmodule
`default_nettype wire

// file: tb/tb_nscr_regs.sv
// Self-checking testbench for the node configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_nscr_regs;
    logic        mclk, nrst, cfg_req, cfg_write, pll_locked, cfg_ack, cfg_err;
    logic        hdr_one_byte, pll_load, pll_bypass, boot_from_jtag, tile_reset, chip_reset;
    logic [7:0]  cfg_regnum, boot_control_pins;
    logic [31:0] cfg_wdata, cfg_rdata, pw;
    logic [4:0]  debug_source;
    logic [15:0] node_id;
    logic [2:0]  pll_out_div;
    logic [12:0] pll_fb_mult;
    logic [6:0]  pll_in_div;
    logic [15:0] switch_clk_div, ref_clk_div;
    logic [31:0] route_dir_low, route_dir_high;
    logic [1:0]  debug_cfg_tile0, debug_cfg_tile1;
    int          fail_count = 0;
    int          num_checks = 0;

    // Identification values are arbitrary
    nscr_regs #(.SW_REVISION(8'h3c), .SW_VERSION(8'h5a), .NUM_LINKS(8'h07),
        .NUM_SW_PROCS(8'h02), .NUM_DEV_PROCS(8'h04),
        .JTAG_ID(32'h0001_2345), .USER_CODE(32'h0000_00c3)) nscr_regs_i (
        .mclk(mclk), .nrst(nrst), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_regnum(cfg_regnum), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .boot_control_pins(boot_control_pins),
        .debug_source(debug_source), .pll_locked(pll_locked), .hdr_one_byte(hdr_one_byte),
        .node_id(node_id), .pll_load(pll_load), .pll_out_div(pll_out_div),
        .pll_fb_mult(pll_fb_mult), .pll_in_div(pll_in_div), .pll_bypass(pll_bypass),
        .boot_from_jtag(boot_from_jtag), .tile_reset(tile_reset), .chip_reset(chip_reset),
        .switch_clk_div(switch_clk_div), .ref_clk_div(ref_clk_div),
        .route_dir_low(route_dir_low), .route_dir_high(route_dir_high),
        .debug_cfg_tile0(debug_cfg_tile0), .debug_cfg_tile1(debug_cfg_tile1));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    // One access: request for one cycle, answer checked just after the edge that takes it
    task automatic acc(input logic w, input logic [7:0] rn, input logic [31:0] wd,
                       input logic er, input logic [31:0] ex);
        @(posedge mclk);
        cfg_req <= 1'b1;
        cfg_write <= w;
        cfg_regnum <= rn;
        cfg_wdata <= wd;
        @(posedge mclk);
        cfg_req <= 1'b0;
        #1;
        chk1("ack", 1'b1, cfg_ack);
        chk1("err", er, cfg_err);
        chk("rdata", ex, cfg_rdata);
    endtask

    task automatic pll_wr(input logic [31:0] wd);
        acc(1, 8'h06, wd, 0, 32'h0);
        chk1("pll_load", 1'b1, pll_load);
        chk("pll_fields", {9'h0, wd[25:23], wd[20:8], wd[6:0]},
            {9'h0, pll_out_div, pll_fb_mult, pll_in_div});
        chk("pll_mode", {30'h0, wd[29], 1'b1}, {30'h0, pll_bypass, boot_from_jtag});
    endtask

    task automatic wait_trst(input int lim, input logic ch);
        int n;
        n = 0;
        while (tile_reset !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (tile_reset !== 1'b1) begin
            fail_count++;
            $display("[ERR] tile_reset expected 1 seen %b", tile_reset);
            tally_and_finish();
        end else begin
            chk1("chip_reset", ch, chip_reset);
        end
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
    endtask

    initial begin
        nrst = 1'b0;
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_regnum = 8'h00;
        cfg_wdata = 32'h0;
        boot_control_pins = 8'ha5;
        debug_source = 5'h1f;
        pll_locked = 1'b0;
        do_reset();
        boot_control_pins <= 8'h00;
        acc(0, 8'h00, 0, 0, 32'h00a5_3c5a);
        acc(0, 8'h01, 0, 0, 32'h0007_0204);
        acc(0, 8'h04, 0, 0, 32'h0);
        acc(0, 8'h05, 0, 0, 32'h0);
        acc(0, 8'h02, 0, 1, 32'h0);
        acc(1, 8'h01, 32'hffff_ffff, 0, 0);
        acc(0, 8'h01, 0, 0, 32'h0007_0204);
        acc(0, 8'h1f, 0, 0, 32'h0000_0013);
        acc(1, 8'h05, 32'hffff_ffff, 0, 0);
        acc(0, 8'h05, 0, 0, 32'h0000_ffff);
        chk("node_id", 32'h0000_ffff, {16'h0, node_id});
        acc(1, 8'h04, 32'h7fff_fe01, 0, 0);
        acc(0, 8'h04, 0, 0, 32'h1);
        chk1("hdr", 1'b1, hdr_one_byte);
        acc(1, 8'h04, 32'h0, 0, 0);
        chk1("hdr", 1'b0, hdr_one_byte);
        // Remaining writable registers, masks and their outputs
        acc(1, 8'h07, 32'hffff_abcd, 0, 0);
        acc(0, 8'h07, 0, 0, 32'h0000_abcd);
        acc(1, 8'h08, 32'h8765_4321, 0, 0);
        acc(0, 8'h08, 0, 0, 32'h0000_4321);
        acc(1, 8'h0c, 32'h1357_9bdf, 0, 0);
        acc(1, 8'h0d, 32'h2468_ace0, 0, 0);
        acc(1, 8'h10, 32'hffff_fffe, 0, 0);
        acc(1, 8'h11, 32'h0000_0001, 0, 0);
        acc(0, 8'h11, 0, 0, 32'h0000_0001);
        chk("swdiv", 32'h0000_abcd, {16'h0, switch_clk_div});
        chk("refdiv", 32'h0000_4321, {16'h0, ref_clk_div});
        chk("dirlo", 32'h1357_9bdf, route_dir_low);
        chk("dirhi", 32'h2468_ace0, route_dir_high);
        chk("dbg", 32'h0000_0021, {26'h0, debug_cfg_tile0, 2'h0, debug_cfg_tile1});
        // Read-only identity, link ranges and unmapped numbers
        acc(0, 8'h09, 0, 0, 32'h0001_2345);
        acc(0, 8'h0a, 0, 0, 32'h0000_00c3);
        acc(1, 8'h0a, 32'hffff_ffff, 0, 0);
        acc(0, 8'h0a, 0, 0, 32'h0000_00c3);
        acc(0, 8'h28, 0, 0, 32'h0);
        acc(1, 8'h47, 32'hffff_ffff, 0, 0);
        acc(0, 8'h88, 0, 0, 32'h0);
        acc(0, 8'ha7, 0, 0, 32'h0);
        acc(0, 8'h29, 0, 1, 32'h0);
        acc(1, 8'ha8, 32'h1, 1, 0);
        // Settings write that waits for lock; writes refused meanwhile
        pw = 32'h3f80_1234;
        pll_wr(pw);
        acc(1, 8'h05, 32'h0, 1, 0);
        acc(0, 8'h05, 0, 0, 32'h0000_ffff);
        chk1("tile_reset", 1'b0, tile_reset);
        @(posedge mclk);
        pll_locked <= 1'b1;
        wait_trst(4, 1'b1);
        acc(0, 8'h06, 0, 0, pw & 32'hc39f_ff7f);
        // No lock wait and no chip reset
        @(posedge mclk);
        pll_locked <= 1'b0;
        pw = 32'hc0ff_ff8f;
        pll_wr(pw);
        wait_trst(1, 1'b0);
        // PLL protection
        acc(1, 8'h04, 32'h0000_0100, 0, 0);
        acc(1, 8'h06, 32'h4000_0001, 1, 0);
        chk1("pll_load", 1'b0, pll_load);
        @(posedge mclk);
        #1;
        chk1("tile_reset", 1'b0, tile_reset);
        acc(0, 8'h06, 0, 0, pw & 32'hc39f_ff7f);
        acc(1, 8'h05, 32'h0000_1234, 0, 0);
        // Global write lock
        acc(1, 8'h04, 32'h8000_0000, 0, 0);
        acc(0, 8'h04, 0, 0, 32'h8000_0000);
        acc(1, 8'h05, 32'h0000_5678, 1, 0);
        acc(1, 8'h04, 32'h0, 1, 0);
        acc(0, 8'h05, 0, 0, 32'h0000_1234);
        acc(1, 8'h07, 32'h0, 1, 0);
        acc(0, 8'h07, 0, 0, 32'h0000_abcd);
        acc(1, 8'h06, 32'h4000_0000, 1, 0);
        chk1("pll_load", 1'b0, pll_load);
        @(posedge mclk);
        do_reset();
        #1;
        chk("ref_clk_div", 32'h0000_0003, {16'h0, ref_clk_div});
        chk("rst_outs", 32'h0, {28'h0, hdr_one_byte, pll_bypass, boot_from_jtag, chip_reset});
        chk("node_id", 32'h0, {16'h0, node_id});
        acc(0, 8'h04, 0, 0, 32'h0);
        acc(0, 8'h08, 0, 0, 32'h3);
        acc(0, 8'h00, 0, 0, 32'h0000_3c5a);
        tally_and_finish();
    end
endmodule

bind nscr_regs nscr_regs_sva nscr_regs_sva_i (
    .mclk(mclk), .nrst(nrst), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_regnum(cfg_regnum), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
    .cfg_rdata(cfg_rdata), .pll_locked(pll_locked), .hdr_one_byte(hdr_one_byte),
    .node_id(node_id), .pll_load(pll_load), .tile_reset(tile_reset), .chip_reset(chip_reset));
`default_nettype wire
